// *** shared/ftcr_map.svh ***
/*
  Register addresses, maxima, reset values and timing figures of the flash and
  torch control bank. Assumes a 50 MHz core clock.
*/
`ifndef FTCR_MAP_SVH
`define FTCR_MAP_SVH

// ==========================================================================
// Register addresses
`define FTCR_ADDR_FLASH 3'h1
`define FTCR_ADDR_TORCH 3'h2
`define FTCR_ADDR_TIMEOUT 3'h3
`define FTCR_ADDR_LOWSUP 3'h4
`define FTCR_ADDR_STTH 3'h5

// ==========================================================================
// Largest legal value per register
`define FTCR_MAX_FLASH 6'h1f
`define FTCR_MAX_TORCH 6'h1f
`define FTCR_MAX_TIMEOUT 6'h07
`define FTCR_MAX_LOWSUP 6'h09
`define FTCR_MAX_STTH 6'h05

// ==========================================================================
// Reset values
`define FTCR_RST_FLASH 5'h04
`define FTCR_RST_TORCH 5'h04
`define FTCR_RST_TIMEOUT 3'h7
`define FTCR_RST_LOWSUP 4'h1

// ==========================================================================
// Field positions
`define FTCR_ON_BIT 4
`define FTCR_CODE_MSB 3

// ==========================================================================
// Current and voltage tables
`define FTCR_FLASH_TOP_MA 11'h4b0
`define FTCR_FLASH_STEP_MA 11'h032
`define FTCR_FLASH_C14_MA 11'h190
`define FTCR_FLASH_C15_MA 11'h0fa
`define FTCR_TORCH_TOP_DMA 12'hbb8
`define FTCR_TORCH_STEP_DMA 12'h07d
`define FTCR_TORCH_C14_DMA 12'h3e8
`define FTCR_TORCH_C15_DMA 12'h271
`define FTCR_LOWSUP_BASE_MV 12'hb54
`define FTCR_LOWSUP_STEP_MV 12'h064
`define FTCR_LAST_LINEAR_CODE 4'hd

// ==========================================================================
// Timing
`define FTCR_CLK_MHZ 50
`define FTCR_TIMEOUT_STEP_US 156250
`define FTCR_TIMEOUT_STEP_CYCLES (`FTCR_TIMEOUT_STEP_US * `FTCR_CLK_MHZ)

`endif

// *** shared/ftcr_pkg.sv ***
/*
  Types shared by the flash and torch control bank.
  Assumes ftcr_map.svh holds the numeric constants.
*/
package ftcr_pkg;
  typedef logic [4:0] ftcr_word_type;
  typedef logic [3:0] ftcr_code_type;
  typedef logic [2:0] ftcr_addr_type;
  typedef logic [5:0] ftcr_data_type;
  typedef enum logic [1:0] {FTCR_IDLE, FTCR_DRIVING, FTCR_EXPIRED} ftcr_timer_type;
endpackage

// *** core/ftcr_core.sv ***
/*
  Write-only control bank of a flash LED driver: takes decoded address/data
  frames, holds the four control words, decodes them into currents, a timeout and a supply threshold, runs the
  safety timer and the low-supply cutoff.
  Assumes the single-wire framer runs on clk, pulses frame_valid once per
  complete frame and raises shutdown_req in the low-power state.
*/
`timescale 1ns/1ps
`include "ftcr_map.svh"

// Notes on behaviour
// (R1) Flash 0-15 loads code, flash stays off
// (R2) Flash 16-31 loads code and enables flash
// (R3) Flash bit 4 enable, bits 3:0 code
// (R4) Flash code maps 1.200A down to 0.250A
// (R5) Torch 0-15 loads code only
// (R6) Torch 16-31 loads code and enables torch
// (R7) Torch enable bit zero keeps torch off
// (R8) Torch bit 4 enable, bits 3:0 code
// (R9) Torch code maps 300.0mA down to 62.5mA
// (R10) Safety timer runs only above threshold current
// (R11) Timeout is 156.25ms times code plus one
// (R12) Below threshold: low flag, driver disabled
// (R13) Low-supply code 0 off, 1-9 3.0-3.8V
// (R14) Flash and torch words reset to 4
// (R15) Timeout resets to 7, low-supply to 1
// (R16) Over-maximum data discards whole frame
// (R17) Addresses: flash 1, torch 2, timeout 3, low-supply 4
// (R18) Shutdown returns all registers to defaults
// (R19) Registers change only on complete valid frame; the code also reloads the defaults on shutdown_req without a frame

module ftcr_core
  import ftcr_pkg::*;
#(
  parameter int unsigned TIMEOUT_STEP_CYCLES = `FTCR_TIMEOUT_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Frame from the single-wire framer
  input wire logic frame_valid,
  input wire ftcr_addr_type frame_addr,
  input wire ftcr_data_type frame_data,
  input wire logic shutdown_req,
  // Analog status inputs, asynchronous
  input wire logic supply_below_th,
  input wire logic led_above_th,
  // Register contents
  output logic flash_on_bit,
  output ftcr_code_type flash_level_code,
  output logic torch_on_bit,
  output ftcr_code_type torch_level_code,
  output logic [2:0] safety_timeout_code,
  output ftcr_code_type low_supply_code,
  // Decoded settings
  output logic [10:0] flash_current_ma,
  output logic [11:0] torch_current_dma,
  output logic [20:0] timeout_us,
  output logic low_supply_enable,
  output logic [11:0] low_supply_mv,
  // Status and drive
  output logic frame_reject,
  output logic low_supply_flag,
  output logic safety_expired,
  output logic flash_drive_en,
  output logic torch_drive_en
);

  // ========================================================================
  // Decode tables
  function automatic logic [10:0] flash_ma(input ftcr_code_type c);
    logic [10:0] r;
    r = `FTCR_FLASH_TOP_MA - 11'(`FTCR_FLASH_STEP_MA * 11'(c));
    if (c == 4'he) begin
      r = `FTCR_FLASH_C14_MA;
    end else if (c == 4'hf) begin
      r = `FTCR_FLASH_C15_MA;
    end
    return r;
  endfunction

  function automatic logic [11:0] torch_dma(input ftcr_code_type c);
    logic [11:0] r;
    r = `FTCR_TORCH_TOP_DMA - 12'(`FTCR_TORCH_STEP_DMA * 12'(c));
    if (c == 4'he) begin
      r = `FTCR_TORCH_C14_DMA;
    end else if (c == 4'hf) begin
      r = `FTCR_TORCH_C15_DMA;
    end
    return r;
  endfunction

  // ========================================================================
  // Synchronisers for the analog comparators
  logic below_s1_q, below_s2_q, above_s1_q, above_s2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      below_s1_q <= 1'b0;
      below_s2_q <= 1'b0;
      above_s1_q <= 1'b0;
      above_s2_q <= 1'b0;
    end else begin
      below_s1_q <= supply_below_th;
      below_s2_q <= below_s1_q;
      above_s1_q <= led_above_th;
      above_s2_q <= above_s1_q;
    end
  end

  // ========================================================================
  // Register file
  ftcr_word_type flash_q, flash_d, torch_q, torch_d;
  logic [2:0] tmo_q, tmo_d;
  ftcr_code_type lows_q, lows_d;
  logic reject_q, reject_d;
  logic [10:0] fma_q, fma_d;
  logic [11:0] tdma_q, tdma_d, lmv_q, lmv_d;
  logic [20:0] tus_q, tus_d;
  logic lsen_q, lsen_d;

  always_comb begin
    flash_d = flash_q;
    torch_d = torch_q;
    tmo_d = tmo_q;
    lows_d = lows_q;
    reject_d = 1'b0;
    if (shutdown_req) begin
      flash_d = `FTCR_RST_FLASH; // R18
      torch_d = `FTCR_RST_TORCH;
      tmo_d = `FTCR_RST_TIMEOUT;
      lows_d = `FTCR_RST_LOWSUP;
    end else if (frame_valid) begin // R19
      case (frame_addr) // R17
        `FTCR_ADDR_FLASH: begin
          if (frame_data > `FTCR_MAX_FLASH) begin
            reject_d = 1'b1; // R16
          end else begin
            flash_d = frame_data[4:0]; // R1 R2
          end
        end
        `FTCR_ADDR_TORCH: begin
          if (frame_data > `FTCR_MAX_TORCH) begin
            reject_d = 1'b1; // R16
          end else begin
            torch_d = frame_data[4:0]; // R5 R6
          end
        end
        `FTCR_ADDR_TIMEOUT: begin
          if (frame_data > `FTCR_MAX_TIMEOUT) begin
            reject_d = 1'b1; // R16
          end else begin
            tmo_d = frame_data[2:0];
          end
        end
        `FTCR_ADDR_LOWSUP: begin
          if (frame_data > `FTCR_MAX_LOWSUP) begin
            reject_d = 1'b1; // R16
          end else begin
            lows_d = frame_data[3:0];
          end
        end
        // Threshold register lives elsewhere; only its range is checked here
        `FTCR_ADDR_STTH: begin
          reject_d = (frame_data > `FTCR_MAX_STTH); // R16
        end
        default: begin
          reject_d = 1'b1; // R17
        end
      endcase
    end
    // Decoded values follow the stored words one cycle later
    fma_d = flash_ma(flash_q[`FTCR_CODE_MSB:0]); // R4
    tdma_d = torch_dma(torch_q[`FTCR_CODE_MSB:0]); // R9
    tus_d = 21'(`FTCR_TIMEOUT_STEP_US * (32'(tmo_q) + 32'd1)); // R11
    lsen_d = (lows_q != 4'h0); // R13
    lmv_d = `FTCR_LOWSUP_BASE_MV + 12'(`FTCR_LOWSUP_STEP_MV * 12'(lows_q)); // R13
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flash_q <= `FTCR_RST_FLASH; // R14
      torch_q <= `FTCR_RST_TORCH; // R14
      tmo_q <= `FTCR_RST_TIMEOUT; // R15
      lows_q <= `FTCR_RST_LOWSUP; // R15
      reject_q <= 1'b0;
      fma_q <= 11'h000;
      tdma_q <= 12'h000;
      tus_q <= 21'h00_0000;
      lsen_q <= 1'b0;
      lmv_q <= 12'h000;
    end else begin
      flash_q <= flash_d;
      torch_q <= torch_d;
      tmo_q <= tmo_d;
      lows_q <= lows_d;
      reject_q <= reject_d;
      fma_q <= fma_d;
      tdma_q <= tdma_d;
      tus_q <= tus_d;
      lsen_q <= lsen_d;
      lmv_q <= lmv_d;
    end
  end

  // ========================================================================
  // Low-supply cutoff
  logic lowf_q, lowf_d;

  always_comb begin
    lowf_d = below_s2_q && (lows_q != 4'h0); // R12 R13
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lowf_q <= 1'b0;
    end else begin
      lowf_q <= lowf_d;
    end
  end

  // ========================================================================
  // Safety timer
  // A step prescaler plus a step count keeps the counter narrow; the
  // prescaler clears in FTCR_IDLE, so there is no step of latency spread and the timeout is exact.
  ftcr_timer_type tst_q, tst_d;
  logic [22:0] pre_q, pre_d;
  logic [2:0] stp_q, stp_d;
  logic active;

  assign active = flash_q[`FTCR_ON_BIT] || torch_q[`FTCR_ON_BIT];

  always_comb begin
    tst_d = tst_q;
    pre_d = pre_q;
    stp_d = stp_q;
    case (tst_q)
      FTCR_IDLE: begin
        pre_d = 23'h00_0000;
        stp_d = 3'h0;
        if (active && above_s2_q && !lowf_q) begin
          tst_d = FTCR_DRIVING;
        end
      end
      FTCR_DRIVING: begin
        if (!active) begin
          tst_d = FTCR_IDLE;
        end else if (above_s2_q) begin // R10
          if (pre_q == 23'(TIMEOUT_STEP_CYCLES - 1)) begin
            pre_d = 23'h00_0000;
            if (stp_q == tmo_q) begin // R11
              tst_d = FTCR_EXPIRED;
            end else begin
              stp_d = stp_q + 3'h1;
            end
          end else begin
            pre_d = pre_q + 23'h00_0001;
          end
        end
      end
      FTCR_EXPIRED: begin
        // Held off until both enables drop, so the host must re-arm
        if (!active) begin
          tst_d = FTCR_IDLE;
        end
      end
      default: begin
        tst_d = FTCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tst_q <= FTCR_IDLE;
      pre_q <= 23'h00_0000;
      stp_q <= 3'h0;
    end else begin
      tst_q <= tst_d;
      pre_q <= pre_d;
      stp_q <= stp_d;
    end
  end

  // ========================================================================
  // Outputs
  assign flash_on_bit = flash_q[`FTCR_ON_BIT]; // R3
  assign flash_level_code = flash_q[`FTCR_CODE_MSB:0]; // R3
  assign torch_on_bit = torch_q[`FTCR_ON_BIT]; // R8
  assign torch_level_code = torch_q[`FTCR_CODE_MSB:0]; // R8
  assign safety_timeout_code = tmo_q;
  assign low_supply_code = lows_q;
  assign flash_current_ma = fma_q;
  assign torch_current_dma = tdma_q;
  assign timeout_us = tus_q;
  assign low_supply_enable = lsen_q;
  assign low_supply_mv = lmv_q;
  assign frame_reject = reject_q;
  assign low_supply_flag = lowf_q;
  assign safety_expired = (tst_q == FTCR_EXPIRED);
  assign flash_drive_en = flash_q[`FTCR_ON_BIT] && !lowf_q && !safety_expired; // R1 R12
  assign torch_drive_en = torch_q[`FTCR_ON_BIT] && !lowf_q && !safety_expired; // R7 R12

endmodule

// *** dv/ftcr_props.sv ***
/*
  Checker for the flash and torch control bank, bound to ftcr_core.
  Assumes a single clock domain and the core's port names.
*/
`timescale 1ns/1ps
module ftcr_props
  import ftcr_pkg::*;
#(
  parameter int unsigned TIMEOUT_STEP_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Frame
  input wire logic frame_valid,
  input wire ftcr_addr_type frame_addr,
  input wire ftcr_data_type frame_data,
  input wire logic shutdown_req,
  // Registers
  input wire logic flash_on_bit,
  input wire ftcr_code_type flash_level_code,
  input wire logic torch_on_bit,
  input wire ftcr_code_type torch_level_code,
  input wire logic [2:0] safety_timeout_code,
  input wire ftcr_code_type low_supply_code,
  // Decoded and status
  input wire logic [10:0] flash_current_ma,
  input wire logic [11:0] torch_current_dma,
  input wire logic [20:0] timeout_us,
  input wire logic low_supply_enable,
  input wire logic frame_reject,
  input wire logic low_supply_flag,
  input wire logic safety_expired,
  input wire logic flash_drive_en,
  input wire logic torch_drive_en
);
  wire logic take = frame_valid && !shutdown_req;
  wire logic [16:0] regs = {flash_on_bit, flash_level_code, torch_on_bit, torch_level_code,
    safety_timeout_code, low_supply_code};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // Assertions
  a_flash_word_map: assert property (
    take && frame_addr == 3'h1 && frame_data < 6'h20 |=> regs[16:12] == $past(frame_data[4:0]))
    else $error("flash word not loaded");
  a_torch_word_map: assert property (
    take && frame_addr == 3'h2 && frame_data < 6'h20 |=> regs[11:7] == $past(frame_data[4:0]))
    else $error("torch word not loaded");
  a_over_max_drop: assert property (
    take && frame_addr == 3'h3 && frame_data > 6'h07 |=> $stable(regs) && frame_reject)
    else $error("over-range frame not discarded");
  a_shutdown_dflt: assert property (shutdown_req |=> regs == 17'h0_4271)
    else $error("shutdown left registers off default");
  a_idle_hold: assert property (!frame_valid && !shutdown_req |=> $stable(regs))
    else $error("registers moved without a frame");
  a_torch_off: assert property (!torch_on_bit |-> !torch_drive_en)
    else $error("torch driven with enable bit clear");
  a_low_cuts: assert property (low_supply_flag |-> !flash_drive_en && !torch_drive_en)
    else $error("driver on during low supply");
  a_low_off: assert property (
    low_supply_code == 4'h0 |=> !low_supply_flag && !low_supply_enable)
    else $error("low supply detection not off");
  a_flash_c14: assert property (flash_level_code == 4'he |=> flash_current_ma == 11'h190)
    else $error("flash code 14 current wrong");
  a_torch_c15: assert property (torch_level_code == 4'hf |=> torch_current_dma == 12'h271)
    else $error("torch code 15 current wrong");
  a_timeout_c0: assert property (safety_timeout_code == 3'h0 |=> timeout_us == 21'h2_625a)
    else $error("minimum timeout wrong");
  c_reject: cover property (frame_reject);
  c_low: cover property (low_supply_flag);
  c_expired: cover property (safety_expired);
endmodule
bind ftcr_core ftcr_props #(.TIMEOUT_STEP_CYCLES(TIMEOUT_STEP_CYCLES)) ftcr_props_i (
  .clk, .rst_b, .frame_valid, .frame_addr, .frame_data, .shutdown_req, .flash_on_bit,
  .flash_level_code, .torch_on_bit, .torch_level_code, .safety_timeout_code,
  .low_supply_code, .flash_current_ma, .torch_current_dma, .timeout_us,
  .low_supply_enable, .frame_reject, .low_supply_flag, .safety_expired, .flash_drive_en,
  .torch_drive_en
);

// *** dv/ftcr_host.sv ***
/*
  Host side model: hands whole address/data frames to the core.
  Assumes the core samples frames on the rising clock edge.
*/
`timescale 1ns/1ps
module ftcr_host
  import ftcr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Frame
  output logic frame_valid,
  output ftcr_addr_type frame_addr,
  output ftcr_data_type frame_data
);
  initial begin
    frame_valid = 1'b0;
    frame_addr = 3'h0;
    frame_data = 6'h00;
  end
  task automatic send(input ftcr_addr_type a, input ftcr_data_type d);
    @(negedge clk);
    frame_valid = 1'b1;
    frame_addr = a;
    frame_data = d;
    @(negedge clk);
    frame_valid = 1'b0;
    // Released lines show junk, so stale data cannot pass for a frame
    frame_addr = ~a;
    frame_data = ~d;
  endtask
endmodule

// *** dv/ftcr_core_tb.sv ***
/*
  Self-checking bench for ftcr_core driven by the host frame model.
  Assumes an 8-cycle timer step so the safety timer expires quickly.
*/
`timescale 1ns/1ps
module ftcr_core_tb;
  import ftcr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic shutdown_req = 1'b0;
  logic supply_below_th = 1'b0;
  logic led_above_th = 1'b0;
  logic frame_valid, flash_on_bit, torch_on_bit, low_supply_enable, frame_reject;
  logic low_supply_flag, safety_expired, flash_drive_en, torch_drive_en;
  ftcr_addr_type frame_addr;
  ftcr_data_type frame_data;
  ftcr_code_type flash_level_code, torch_level_code, low_supply_code;
  logic [2:0] safety_timeout_code;
  logic [10:0] flash_current_ma;
  logic [11:0] torch_current_dma, low_supply_mv;
  logic [20:0] timeout_us;
  int mismatches = 0;
  int num_checks = 0;
  wire logic [16:0] regs = {flash_on_bit, flash_level_code, torch_on_bit, torch_level_code,
    safety_timeout_code, low_supply_code};
  always #10 clk = ~clk;
  ftcr_host ftcr_host_i (.clk, .frame_valid, .frame_addr, .frame_data);
  ftcr_core #(.TIMEOUT_STEP_CYCLES(8)) ftcr_core_i (.clk, .rst_b, .frame_valid, .frame_addr,
    .frame_data, .shutdown_req, .supply_below_th, .led_above_th, .flash_on_bit,
    .flash_level_code, .torch_on_bit, .torch_level_code, .safety_timeout_code,
    .low_supply_code, .flash_current_ma, .torch_current_dma, .timeout_us,
    .low_supply_enable, .low_supply_mv, .frame_reject, .low_supply_flag, .safety_expired,
    .flash_drive_en, .torch_drive_en);
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    @(negedge clk);
    chk(21'(regs), 21'h0_4271);
    chk(timeout_us, 21'h13_12d0);
  endtask
  task automatic t_levels;
    int c, e;
    for (int a = 1; a < 3; a++) begin
      for (int d = 0; d < 32; d++) begin
        c = d % 16;
        e = c < 14 ? 1200 - 50 * c : (c < 15 ? 400 : 250);
        if (a == 2) e = c < 14 ? 3000 - 125 * c : (c < 15 ? 1000 : 625);
        ftcr_host_i.send(3'(a), 6'(d));
        @(negedge clk);
        chk(21'(a == 1 ? regs[16:12] : regs[11:7]), 21'(d));
        chk(21'(a == 1 ? flash_drive_en : torch_drive_en), 21'(d / 16));
        chk(21'(a == 1 ? 12'(flash_current_ma) : torch_current_dma), 21'(e));
      end
    end
  endtask
  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      ftcr_host_i.send(3'h3, 6'(c));
      @(negedge clk);
      chk(timeout_us, 21'(156250 * (c + 1)));
    end
    for (int c = 0; c < 10; c++) begin
      ftcr_host_i.send(3'h4, 6'(c));
      @(negedge clk);
      chk(21'(low_supply_enable), 21'(c != 0));
      if (c > 0) chk(21'(low_supply_mv), 21'(2900 + 100 * c));
    end
  endtask
  task automatic t_bad;
    ftcr_addr_type ta[9] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h6, 3'h7, 3'h5, 3'h5};
    ftcr_data_type td[9] = '{6'h20, 6'h3f, 6'h08, 6'h0a, 6'h01, 6'h01, 6'h01, 6'h02, 6'h06};
    logic [16:0] snap;
    for (int i = 0; i < 9; i++) begin
      snap = regs;
      ftcr_host_i.send(ta[i], td[i]);
      chk(21'(regs), 21'(snap));
      chk(21'(frame_reject), 21'(i != 7));
    end
  endtask
  task automatic t_lowsup;
    int n;
    ftcr_host_i.send(3'h4, 6'h01);
    ftcr_host_i.send(3'h1, 6'h10);
    supply_below_th = 1'b1;
    n = 0;
    while (low_supply_flag !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(21'(n), 21'h3);
    if (n > 7) close_out();
    chk(21'(flash_drive_en), 21'h0);
    ftcr_host_i.send(3'h4, 6'h00);
    @(negedge clk);
    chk(21'({low_supply_flag, flash_drive_en}), 21'h1);
    supply_below_th = 1'b0;
  endtask
  task automatic t_timer;
    int n;
    ftcr_host_i.send(3'h3, 6'h00);
    repeat (20) @(negedge clk);
    chk(21'(safety_expired), 21'h0);
    led_above_th = 1'b1;
    n = 0;
    while (safety_expired !== 1'b1 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk(21'(n > 8 && n < 16), 21'h1);
    if (n > 29) close_out();
    chk(21'({flash_drive_en, torch_drive_en}), 21'h0);
    ftcr_host_i.send(3'h1, 6'h00);
    ftcr_host_i.send(3'h2, 6'h00);
    @(negedge clk);
    chk(21'(safety_expired), 21'h0);
    led_above_th = 1'b0;
  endtask
  task automatic t_shutdown;
    ftcr_host_i.send(3'h2, 6'h19);
    shutdown_req = 1'b1;
    ftcr_host_i.send(3'h2, 6'h14);
    chk(21'(frame_reject), 21'h0);
    chk(21'(regs), 21'h0_4271);
    shutdown_req = 1'b0;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_levels();
    t_codes();
    t_bad();
    t_lowsup();
    t_timer();
    t_shutdown();
    close_out();
  end
endmodule
